// ---- rtl/sys_cfg_consts.vh ----
// constants for the stack page and bus configuration block
// Notes on behaviour
// - eight-bit stack page register supplies stack page
// - reset clears stack page to zero
// - page selects one 64K data division
// - internal RAM sits at 00c000h-00dfffh
// - single chip mode keeps stack in page zero
// - stack pointer starts e000h, pre-decrements
// - set enable routes chip enable to pin
// - single chip mode forces plain port outputs
`ifndef SYS_CFG_CONSTS_VH
`define SYS_CFG_CONSTS_VH
`define ADDR_BUS_CFG 24'h00ff00
`define ADDR_STACK_PAGE 24'h00ff01
`define BIT_BUS_MODE 7
`define BIT_CPU_MODE 6
`define BIT_CE3 3
`define BIT_CE2 2
`define BIT_CE1 1
`define RST_BUS_CFG 8'h00
`define RST_STACK_PAGE 8'h00
`define RST_STACK_PTR 16'he000
`define IRAM_LO 24'h00c000
`define IRAM_HI 24'h00dfff
`endif

// ---- rtl/ce_pin_mux.v ----
// one shared port pin: chip enable or plain port output
`timescale 1ns/1ps
`default_nettype none
module ce_pin_mux (
  input wire clk_i, // system clock
  input wire rst_b_i, // async reset, active low
  input wire enable_i, // chip enable routing bit
  input wire expand_i, // bus mode: 1 expansion
  input wire ce_b_i, // decoder chip enable, active low
  input wire port_i, // port data latch value
  output reg pin_o // pin level
);
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_o <= 1'b1;
    end else if (enable_i && expand_i) begin
      pin_o <= ce_b_i;
    end else begin
      pin_o <= port_i;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/stack_page_and_bus_config.v ----
// stack page register, bus configuration register and pin routing
`timescale 1ns/1ps
`default_nettype none
`include "sys_cfg_consts.vh"
module stack_page_and_bus_config (
  input wire clk_i, // system clock, 40 MHz
  input wire rst_b_i, // async initial reset, active low
  input wire [23:0] addr_i, // cpu i/o address
  input wire wr_i, // write strobe, one cycle
  input wire rd_i, // read strobe, one cycle
  input wire [7:0] wdata_i, // write data
  output reg [7:0] rdata_o, // read data, valid cycle after rd_i
  input wire sp_load_i, // load stack pointer from sp_data_i
  input wire [15:0] sp_data_i, // stack pointer load value
  input wire push_i, // push: pre-decrement pointer
  input wire pop_i, // pop: post-increment pointer
  output reg [23:0] stack_addr_o, // full stack address of current top
  input wire [2:0] ce_b_i, // decoder chip enables 1..3, active low
  input wire [2:0] port_i, // port 3 lines 1..3 data latch
  output wire port3_line_one_out, // shared pin 1
  output wire port3_line_two_out, // shared pin 2
  output wire port3_line_three_out, // shared pin 3
  output reg bus_mode_o, // 1 expansion, 0 single chip
  output reg cpu_mode_o // 1 maximum, 0 minimum
);

  // reset images and register addresses, sized for this block
  localparam [7:0] CFG_RST = `RST_BUS_CFG;
  localparam [7:0] PAGE_RST = `RST_STACK_PAGE;
  localparam [15:0] PTR_RST = `RST_STACK_PTR;
  localparam [23:0] CFG_ADDR = `ADDR_BUS_CFG;
  localparam [23:0] PAGE_ADDR = `ADDR_STACK_PAGE;

  reg [7:0] stack_page_bits_r;
  reg [7:0] stack_page_bits_nxt;
  reg [7:0] stack_page_eff;
  reg [2:0] ce_en_r;
  reg [2:0] ce_en_nxt;
  reg bus_mode_nxt;
  reg cpu_mode_nxt;
  reg [7:0] rdata_nxt;
  reg [15:0] stack_pointer_r;
  reg [15:0] stack_pointer_nxt;
  reg [23:0] stack_addr_nxt;
  wire hit_cfg;
  wire hit_page;
  wire wr_cfg;
  wire wr_page;
  wire [2:0] pins;

  // true when the cpu address names the given register
  function sel;
    input [23:0] a;
    input [23:0] target;
    begin
      sel = (a == target);
    end
  endfunction

  // read image of the configuration register; unused bits read zero
  function [7:0] cfg_image;
    input bus_mode;
    input cpu_mode;
    input [2:0] ce_en;
    begin
      cfg_image = 8'h00;
      cfg_image[`BIT_BUS_MODE] = bus_mode;
      cfg_image[`BIT_CPU_MODE] = cpu_mode;
      cfg_image[`BIT_CE3:`BIT_CE1] = ce_en;
    end
  endfunction

  // page used by stack accesses; single chip has only page zero
  function [7:0] eff_page;
    input bus_mode;
    input [7:0] page;
    begin
      if (bus_mode) begin
        eff_page = page;
      end else begin
        eff_page = 8'h00;
      end
    end
  endfunction

  assign hit_cfg = sel(addr_i, CFG_ADDR);
  assign hit_page = sel(addr_i, PAGE_ADDR);
  assign wr_cfg = wr_i & hit_cfg;
  assign wr_page = wr_i & hit_page;

  // configuration register: one write updates every field
  always @* begin
    bus_mode_nxt = bus_mode_o;
    cpu_mode_nxt = cpu_mode_o;
    ce_en_nxt = ce_en_r;
    if (wr_cfg) begin
      bus_mode_nxt = wdata_i[`BIT_BUS_MODE];
      cpu_mode_nxt = wdata_i[`BIT_CPU_MODE];
      ce_en_nxt = wdata_i[`BIT_CE3:`BIT_CE1];
    end
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus_mode_o <= CFG_RST[`BIT_BUS_MODE];
    end else begin
      bus_mode_o <= bus_mode_nxt;
    end
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cpu_mode_o <= CFG_RST[`BIT_CPU_MODE];
    end else begin
      cpu_mode_o <= cpu_mode_nxt;
    end
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ce_en_r <= CFG_RST[`BIT_CE3:`BIT_CE1];
    end else begin
      ce_en_r <= ce_en_nxt;
    end
  end

  always @* begin
    stack_page_bits_nxt = stack_page_bits_r;
    if (wr_page) begin
      stack_page_bits_nxt = wdata_i;
    end
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stack_page_bits_r <= PAGE_RST;
    end else begin
      stack_page_bits_r <= stack_page_bits_nxt;
    end
  end

  // read data holds until the next read strobe
  always @* begin
    rdata_nxt = rdata_o;
    if (rd_i) begin
      if (hit_cfg) begin
        rdata_nxt = cfg_image(bus_mode_o, cpu_mode_o, ce_en_r);
      end else if (hit_page) begin
        rdata_nxt = stack_page_bits_r;
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= rdata_nxt;
    end
  end

  // load wins over push, push over pop
  always @* begin
    stack_pointer_nxt = stack_pointer_r;
    if (sp_load_i) begin
      stack_pointer_nxt = sp_data_i;
    end else if (push_i) begin
      stack_pointer_nxt = stack_pointer_r - 16'h0001;
    end else if (pop_i) begin
      stack_pointer_nxt = stack_pointer_r + 16'h0001;
    end
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stack_pointer_r <= PTR_RST;
    end else begin
      stack_pointer_r <= stack_pointer_nxt;
    end
  end

  // page picks the 64K division of data memory
  always @* begin
    stack_page_eff = eff_page(bus_mode_o, stack_page_bits_r);
  end

  // the stack address shows the pointer after this cycle's update; a page write shows one cycle later
  always @* begin
    stack_addr_nxt = {stack_page_eff, stack_pointer_nxt};
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stack_addr_o <= {PAGE_RST, PTR_RST};
    end else begin
      stack_addr_o <= stack_addr_nxt;
    end
  end

  // each shared pin gets its own routing flip-flop
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : pin_gen
      ce_pin_mux u_mux (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .enable_i(ce_en_r[g]),
        .expand_i(bus_mode_o),
        .ce_b_i(ce_b_i[g]),
        .port_i(port_i[g]),
        .pin_o(pins[g])
      );
    end
  endgenerate

  assign port3_line_one_out = pins[0];
  assign port3_line_two_out = pins[1];
  assign port3_line_three_out = pins[2];
endmodule
`default_nettype wire

// ---- dv/sys_cfg_checker.sv ----
// assertion checker for the stack page and bus configuration block
`timescale 1ns/1ps
`default_nettype none
module sys_cfg_checker (
  input wire logic clk_i, // system clock
  input wire logic rst_b_i, // reset, active low
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  input wire logic sp_load_i, // stack pointer load
  input wire logic push_i, // push strobe
  input wire logic [23:0] addr_i, // register address
  input wire logic [7:0] wdata_i, // write data
  input wire logic [7:0] rdata_o, // read data
  input wire logic [23:0] stack_addr_o, // stack top address
  input wire logic bus_mode_o, // bus mode bit
  input wire logic cpu_mode_o, // cpu mode bit
  input wire logic port3_line_one_out, // shared pin 1
  input wire logic [2:0] port_i // port latch values
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_page_wr;
    wr_i && addr_i == 24'h00ff01;
  endsequence
  sequence s_expand_idle;
    !wr_i && bus_mode_o;
  endsequence
  a_page_used: assert property (s_page_wr ##1 s_expand_idle |=>
    stack_addr_o[23:16] == $past(wdata_i, 2))
    else $error("stack page not applied");
  a_reset_top: assert property ($rose(rst_b_i) |-> stack_addr_o == 24'h00e000)
    else $error("stack top wrong after reset");
  a_reset_modes: assert property ($rose(rst_b_i) |-> !bus_mode_o && !cpu_mode_o)
    else $error("mode bits set after reset");
  a_push_dec: assert property (push_i && !sp_load_i |=>
    stack_addr_o[15:0] == $past(stack_addr_o[15:0]) - 16'h1)
    else $error("push did not decrement");
  a_single_page0: assert property (push_i && !bus_mode_o |=> stack_addr_o[23:16] == 8'h00)
    else $error("page not zero in single chip");
  a_pin_single: assert property (!bus_mode_o |=> port3_line_one_out == $past(port_i[0]))
    else $error("pin not port output");
  a_read_mode: assert property (rd_i && addr_i == 24'h00ff00 |=>
    rdata_o[7:4] == {$past(bus_mode_o), $past(cpu_mode_o), 2'b00} && !rdata_o[0])
    else $error("config read wrong");
  a_rdata_hold: assert property (!rd_i |=> $stable(rdata_o))
    else $error("read data moved");
  a_unmapped_read: assert property (rd_i && addr_i[23:1] != 23'h7f80 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind stack_page_and_bus_config sys_cfg_checker chk_u (
  .clk_i(clk_i),
  .rst_b_i(rst_b_i),
  .wr_i(wr_i),
  .rd_i(rd_i),
  .sp_load_i(sp_load_i),
  .push_i(push_i),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .rdata_o(rdata_o),
  .stack_addr_o(stack_addr_o),
  .bus_mode_o(bus_mode_o),
  .cpu_mode_o(cpu_mode_o),
  .port3_line_one_out(port3_line_one_out),
  .port_i(port_i)
);
`default_nettype wire

// ---- dv/stack_page_and_bus_config_tb.sv ----
// testbench for the stack page and bus configuration block
`timescale 1ns/1ps
`default_nettype none
module stack_page_and_bus_config_tb;
  logic clk_i = 0, rst_b_i = 0, wr_i = 0, rd_i = 0, sp_load_i = 0, push_i = 0, pop_i = 0;
  logic [23:0] addr_i = 0, stack_addr_o;
  logic [7:0] wdata_i = 0, rdata_o;
  logic [15:0] sp_data_i = 0;
  logic [2:0] ce_b_i = 3'b010, port_i = 3'b101;
  logic port3_line_one_out, port3_line_two_out, port3_line_three_out, bus_mode_o, cpu_mode_o;
  int n_fail = 0, cmp_count = 0;
  stack_page_and_bus_config uut (.*);
  initial forever #12.5 clk_i = ~clk_i;
  task chk(input logic [23:0] seen, exp, input string nm);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [23:0] a, input logic [7:0] d);
    @(posedge clk_i); addr_i <= a; wdata_i <= d; wr_i <= 1;
    @(posedge clk_i); wr_i <= 0;
  endtask
  task rd(input logic [23:0] a, exp, input string nm);
    @(posedge clk_i); addr_i <= a; rd_i <= 1;
    @(posedge clk_i); rd_i <= 0;
    #1 chk(rdata_o, exp, nm);
  endtask
  task sp(input logic ld, input logic [15:0] v, input logic [23:0] exp);
    @(posedge clk_i); sp_load_i <= ld; push_i <= !ld; sp_data_i <= v;
    @(posedge clk_i); sp_load_i <= 0; push_i <= 0;
    #1 chk(stack_addr_o, exp, "stack_addr");
  endtask
  task pop(input logic [23:0] exp);
    @(posedge clk_i); pop_i <= 1;
    @(posedge clk_i); pop_i <= 0;
    #1 chk(stack_addr_o, exp, "stack_addr");
  endtask
  task pins(input logic [2:0] exp);
    @(posedge clk_i);
    #1 chk({port3_line_three_out, port3_line_two_out, port3_line_one_out}, exp, "pins");
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #10000;
    n_fail++;
    end_of_test;
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1;
    rd(24'h00ff00, 0, "cfg");
    chk({bus_mode_o, cpu_mode_o}, 2'b00, "modes");
    rd(24'h00ff01, 0, "page");
    chk(stack_addr_o, 24'h00e000, "top");
    pins(3'b101);
    sp(0, 0, 24'h00dfff);
    wr(24'h00ff01, 8'h05);
    sp(0, 0, 24'h00dffe);
    wr(24'h00ff00, 8'hff);
    rd(24'h00ff00, 8'hce, "cfg");
    chk({bus_mode_o, cpu_mode_o}, 2'b11, "modes");
    pins(3'b010);
    sp(0, 0, 24'h05dffd);
    wr(24'h00ff01, 8'h27);
    sp(1, 16'h1234, 24'h271234);
    pop(24'h271235);
    wr(24'h00ff00, 8'h80);
    pins(3'b101);
    chk({bus_mode_o, cpu_mode_o}, 2'b10, "modes");
    wr(24'h00ff00, 8'h0e);
    pins(3'b101);
    rd(24'h00ff02, 0, "unmapped");
    @(posedge clk_i);
    rst_b_i <= 0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1;
    rd(24'h00ff01, 0, "page");
    chk(stack_addr_o, 24'h00e000, "top");
    end_of_test;
  end
endmodule
`default_nettype wire
